// ---- core/rfa_acq_ctrl.sv ----
// Acquisition front-end control: APB registers, converter paths, auxiliary I2S stream and FIFO.
// Assumes PDM bits from the analog converters arrive asynchronously; all logic on i_core_clk.
// Function
// - Capture six-bit RF converter sample after analog filtering.
// - Gain bits 7:4 set first summing RF amplifier gain.
// - Gain bits 3:0 set AGC gain, writable anytime without stopping path.
// - Six-bit sign-magnitude offset trim drives offset compensation converter.
// - Config A bits 6:4 select node routed to monitor pin buffer.
// - Config A also holds noise filter roll-off selection.
// - Power-down bits 5:0 switch off analog RF blocks individually.
// - Bypass bit 1 feeds RF converter from monitor pin, skipping front stages.
// - Two GP converters, shared 0/2 and 1/3; select picks inputs 2,3.
// - GP outputs low-pass filtered and decimated, then optional fine offset added.
// - Each GP channel result held as ten-bit value in registers.
// - Each GP input has its own interrupt line.
// - Aux inputs share LF converter pair with diodes; exclusive.
// - Aux channels PDM-filtered and decimated to ten-bit samples.
// - Aux samples reformatted into I2S stream for the handler.
// - Handler buffers aux audio in twelve-entry FIFO.
// - Dedicated mux control register selects shared converter input pairs.
`timescale 1ns/1ns
`include "rfa_map.svh"
module rfa_acq_ctrl #(
    parameter int DEC_LEN = `RFA_DEC_LEN,
    parameter int FIFO_DEPTH = `RFA_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Analog converter data
    input wire logic [5:0] i_rf_sample,
    input wire logic [1:0] i_gp_pdm,
    input wire logic [1:0] i_lf_pdm,
    // Analog controls and streams
    output rfa_pkg::rfa_analog_ctrl_s o_analog_ctrl,
    output rfa_pkg::rfa_mux_s o_mux,
    output logic [5:0] o_rf_data,
    output rfa_pkg::rfa_i2s_s o_i2s,
    output logic [3:0] o_gp_irq,
    output logic o_irq
);
    import rfa_pkg::*;

    localparam int CW = $clog2(DEC_LEN + 1);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int NP = 4;

    logic [7:0] gain_r, trim_r, cfga_r, pdn_r, byp_r, mux_r;
    logic [`RFA_FOFS_HI:0] fofs_r [2];
    logic [`RFA_IRQ_N-1:0] ist_r, imsk_r, ev;
    logic [`RFA_SAMP_BITS-1:0] gp_val_r [4];
    logic [`RFA_SAMP_BITS-1:0] aux_val_r [2];
    logic [`RFA_SAMP_BITS-1:0] fifo_r [FIFO_DEPTH];
    logic [PW-1:0] wp_r, rp_r;
    logic [LW-1:0] lvl_r;
    logic [CW-1:0] dec_cnt_r;
    logic [CW-1:0] acc_r [NP];
    logic [2:0] sync_r [NP];
    logic [NP-1:0] pdm_ok;
    wire logic [NP-1:0] pdm_raw = {i_lf_pdm, i_gp_pdm};
    logic dec_tick, wr_en, rd_en, fifo_push, fifo_pop, fifo_ovf;
    logic [`RFA_ADDR_W-1:0] addr;
    logic [31:0] rd_nxt;
    logic [`RFA_SAMP_BITS-1:0] fifo_in;
    rfa_acc_e acc_r_st;

    wire logic addr_ok = (i_paddr[31:`RFA_ADDR_W] == '0);
    assign addr = i_paddr[`RFA_ADDR_W-1:0];
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok && (acc_r_st == RFA_ACC_IDLE);
    assign rd_en = i_psel && i_penable && !i_pwrite && (acc_r_st == RFA_ACC_IDLE);

    // One wait state: answer comes at the second access-phase edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r_st <= RFA_ACC_IDLE;
        end else begin
            unique case (acc_r_st)
                RFA_ACC_IDLE: if (i_psel && i_penable) acc_r_st <= RFA_ACC_DONE;
                RFA_ACC_DONE: acc_r_st <= RFA_ACC_IDLE;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_r <= `RFA_RST_8;
            trim_r <= `RFA_RST_8;
            cfga_r <= `RFA_RST_8;
            pdn_r <= `RFA_RST_8;
            byp_r <= `RFA_RST_8;
            mux_r <= `RFA_RST_8;
            fofs_r[0] <= `RFA_RST_10;
            fofs_r[1] <= `RFA_RST_10;
            imsk_r <= '0;
        end else if (wr_en) begin
            unique case (addr)
                `RFA_OFS_GAIN: gain_r <= i_pwdata[7:0];
                `RFA_OFS_TRIM: trim_r <= i_pwdata[7:0];
                `RFA_OFS_CFGA: cfga_r <= i_pwdata[7:0];
                `RFA_OFS_PDN: pdn_r <= i_pwdata[7:0];
                `RFA_OFS_BYP: byp_r <= i_pwdata[7:0];
                `RFA_OFS_MUX: mux_r <= i_pwdata[7:0];
                `RFA_OFS_FOFS0: fofs_r[0] <= i_pwdata[`RFA_FOFS_HI:0];
                `RFA_OFS_FOFS1: fofs_r[1] <= i_pwdata[`RFA_FOFS_HI:0];
                `RFA_OFS_IMSK: imsk_r <= i_pwdata[`RFA_IRQ_N-1:0];
                default: ;
            endcase
        end
    end

    // Analog controls are registered copies so they change only after a write
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_analog_ctrl <= '0;
            o_mux <= '0;
        end else begin
            o_analog_ctrl.amp1_gain <= gain_r[`RFA_AMP1_HI:`RFA_AMP1_LO];
            o_analog_ctrl.agc_gain <= gain_r[`RFA_AGC_HI:`RFA_AGC_LO];
            o_analog_ctrl.offset_trim <= trim_r[`RFA_TRIM_HI:0];
            o_analog_ctrl.eye_monitor_select <= cfga_r[`RFA_MON_HI:`RFA_MON_LO];
            o_analog_ctrl.noise_rolloff <= cfga_r[`RFA_ROLL_HI:`RFA_ROLL_LO];
            o_analog_ctrl.powerdown <= pdn_r[`RFA_PDN_HI:0];
            o_analog_ctrl.bypass_from_monitor <= byp_r[`RFA_BYP_BIT];
            o_mux.gp_pair_hi <= mux_r[`RFA_MUX_GP_BIT];
            o_mux.aux_sel <= mux_r[`RFA_MUX_AUX_BIT];
        end
    end

    // RF sample capture from the converter
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rf_data <= '0;
        end else begin
            o_rf_data <= i_rf_sample;
        end
    end

    // PDM input synchronisers and decimating counters, one per stream
    // A level counts once the last two flops agree, so one-cycle glitches are dropped
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pdm
            wire logic raw = pdm_raw[g];
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync_r[g] <= '0;
                    pdm_ok[g] <= 1'b0;
                end else begin
                    sync_r[g] <= {sync_r[g][1:0], raw};
                    if (sync_r[g][1] == sync_r[g][2]) pdm_ok[g] <= sync_r[g][2];
                end
            end
            // Boxcar low-pass and decimation: count of ones over DEC_LEN cycles
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    acc_r[g] <= '0;
                end else if (dec_tick) begin
                    acc_r[g] <= CW'(pdm_ok[g]);
                end else begin
                    acc_r[g] <= acc_r[g] + CW'(pdm_ok[g]);
                end
            end
        end
    endgenerate

    assign dec_tick = (dec_cnt_r == CW'(DEC_LEN - 1));

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dec_cnt_r <= '0;
        end else begin
            dec_cnt_r <= dec_tick ? '0 : dec_cnt_r + 1'b1;
        end
    end

    function automatic logic [`RFA_SAMP_BITS-1:0] scale(input logic [CW-1:0] a);
        logic [`RFA_SAMP_BITS+CW-1:0] w;
        w = (`RFA_SAMP_BITS+CW)'(a) * (`RFA_SAMP_BITS+CW)'(1023);
        scale = `RFA_SAMP_BITS'(w / (`RFA_SAMP_BITS+CW)'(DEC_LEN));
    endfunction : scale

    // Fine offset is clamped so a full-scale reading cannot wrap round to zero
    function automatic logic [`RFA_SAMP_BITS-1:0] add_sat(input logic [`RFA_SAMP_BITS-1:0] a,
        input logic [`RFA_SAMP_BITS-1:0] b);
        logic [`RFA_SAMP_BITS:0] s;
        s = {1'b0, a} + {1'b0, b};
        add_sat = s[`RFA_SAMP_BITS] ? '1 : s[`RFA_SAMP_BITS-1:0];
    endfunction : add_sat

    // GP results per channel; inactive pair holds its last value
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 4; i++) gp_val_r[i] <= `RFA_RST_10;
            aux_val_r[0] <= `RFA_RST_10;
            aux_val_r[1] <= `RFA_RST_10;
        end else if (dec_tick) begin
            for (int c = 0; c < 2; c++) begin
                gp_val_r[{mux_r[`RFA_MUX_GP_BIT], 1'(c)}] <=
                    add_sat(scale(acc_r[c]), fofs_r[c]);
            end
            if (mux_r[`RFA_MUX_AUX_BIT]) begin
                aux_val_r[0] <= scale(acc_r[2]);
                aux_val_r[1] <= scale(acc_r[3]);
            end
        end
    end

    // I2S serialiser: bit clock at half the core rate, left then right, MSB first
    // Data and word select change with the falling bit clock so they stand across its rise
    logic [5:0] bit_r;
    logic [2*`RFA_I2S_HALF-1:0] shf_r;
    logic ser_busy_r;
    wire logic aux_new = dec_tick && mux_r[`RFA_MUX_AUX_BIT];
    wire logic ser_last = ser_busy_r && (&bit_r);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_r <= '0;
            shf_r <= `RFA_RST_32;
            ser_busy_r <= 1'b0;
            o_i2s <= '0;
        end else begin
            o_i2s.sck <= ser_busy_r && bit_r[0];
            if (aux_new && (!ser_busy_r || ser_last)) begin
                // A new frame may follow on the last phase of the old one with no gap
                shf_r <= {aux_val_r[0], 6'h00, aux_val_r[1], 6'h00};
                bit_r <= '0;
                ser_busy_r <= 1'b1;
            end else if (ser_busy_r) begin
                if (!bit_r[0]) begin
                    o_i2s.sd <= shf_r[31];
                    o_i2s.ws <= bit_r[5];
                    shf_r <= {shf_r[30:0], 1'b0};
                end
                bit_r <= bit_r + 1'b1;
                if (ser_last) ser_busy_r <= 1'b0;
            end
        end
    end

    // Twelve-entry sample FIFO read by software, left then right
    logic push_side_r;
    assign fifo_push = aux_new || push_side_r;
    assign fifo_in = aux_new ? aux_val_r[0] : aux_val_r[1];
    assign fifo_pop = rd_en && addr_ok && (addr == `RFA_OFS_FIFO) && (lvl_r != '0);
    assign fifo_ovf = fifo_push && (lvl_r == LW'(FIFO_DEPTH)) && !fifo_pop;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            lvl_r <= '0;
            push_side_r <= 1'b0;
        end else begin
            push_side_r <= aux_new;
            if (fifo_push && !fifo_ovf) begin
                fifo_r[wp_r] <= fifo_in;
                wp_r <= (wp_r == PW'(FIFO_DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (fifo_pop) rp_r <= (rp_r == PW'(FIFO_DEPTH - 1)) ? '0 : rp_r + 1'b1;
            lvl_r <= lvl_r + LW'(fifo_push && !fifo_ovf) - LW'(fifo_pop);
        end
    end

    // Sticky interrupts: per-GP-channel ready, FIFO overflow, aux sample ready
    always_comb begin
        ev = '0;
        for (int c = 0; c < 2; c++) ev[{mux_r[`RFA_MUX_GP_BIT], 1'(c)}] = dec_tick;
        ev[`RFA_IRQ_OVF] = fifo_ovf;
        ev[`RFA_IRQ_AUX] = aux_new;
    end

    // Write one to clear; an event in the same cycle as its clear wins
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ist_r <= '0;
        end else begin
            if (wr_en && addr == `RFA_OFS_IST) ist_r <= (ist_r & ~i_pwdata[`RFA_IRQ_N-1:0]) | ev;
            else ist_r <= ist_r | ev;
        end
    end

    // Interrupt lines follow the masked status one cycle later
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
            o_gp_irq <= '0;
        end else begin
            o_irq <= |(ist_r & imsk_r);
            o_gp_irq <= ist_r[3:0] & imsk_r[3:0];
        end
    end

    // Read mux
    always_comb begin
        rd_nxt = `RFA_RST_32;
        unique case (addr)
            `RFA_OFS_GAIN: rd_nxt[7:0] = gain_r;
            `RFA_OFS_TRIM: rd_nxt[7:0] = trim_r;
            `RFA_OFS_CFGA: rd_nxt[7:0] = cfga_r;
            `RFA_OFS_PDN: rd_nxt[7:0] = pdn_r;
            `RFA_OFS_BYP: rd_nxt[7:0] = byp_r;
            `RFA_OFS_MUX: rd_nxt[7:0] = mux_r;
            `RFA_OFS_FOFS0: rd_nxt[`RFA_FOFS_HI:0] = fofs_r[0];
            `RFA_OFS_FOFS1: rd_nxt[`RFA_FOFS_HI:0] = fofs_r[1];
            `RFA_OFS_GP0: rd_nxt[`RFA_SAMP_BITS-1:0] = gp_val_r[0];
            `RFA_OFS_GP1: rd_nxt[`RFA_SAMP_BITS-1:0] = gp_val_r[1];
            `RFA_OFS_GP2: rd_nxt[`RFA_SAMP_BITS-1:0] = gp_val_r[2];
            `RFA_OFS_GP3: rd_nxt[`RFA_SAMP_BITS-1:0] = gp_val_r[3];
            `RFA_OFS_FIFO: rd_nxt[`RFA_SAMP_BITS-1:0] = (lvl_r != '0) ? fifo_r[rp_r] : '0;
            `RFA_OFS_FLVL: rd_nxt[LW-1:0] = lvl_r;
            `RFA_OFS_IST: rd_nxt[`RFA_IRQ_N-1:0] = ist_r;
            `RFA_OFS_IMSK: rd_nxt[`RFA_IRQ_N-1:0] = imsk_r;
            default: rd_nxt = `RFA_RST_32;
        endcase
    end

    // APB answer, registered
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= `RFA_RST_32;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && (acc_r_st == RFA_ACC_IDLE);
            o_pslverr <= i_psel && i_penable && (acc_r_st == RFA_ACC_IDLE) &&
                (addr > `RFA_OFS_IMSK || addr[1:0] != 2'b00 || i_paddr[31:`RFA_ADDR_W] != '0);
            if (rd_en) o_prdata <= addr_ok ? rd_nxt : `RFA_RST_32;
        end
    end
endmodule : rfa_acq_ctrl

// ---- core/rfa_map.svh ----
// Register offsets, field positions, reset values and timing counts of the acquisition control.
// Assumes inclusion from the package and from the top module only.
`ifndef RFA_MAP_SVH
`define RFA_MAP_SVH
`define RFA_OFS_GAIN 12'h000
`define RFA_OFS_TRIM 12'h004
`define RFA_OFS_CFGA 12'h008
`define RFA_OFS_PDN 12'h00C
`define RFA_OFS_BYP 12'h010
`define RFA_OFS_MUX 12'h014
`define RFA_OFS_FOFS0 12'h018
`define RFA_OFS_FOFS1 12'h01C
`define RFA_OFS_GP0 12'h020
`define RFA_OFS_GP1 12'h024
`define RFA_OFS_GP2 12'h028
`define RFA_OFS_GP3 12'h02C
`define RFA_OFS_FIFO 12'h030
`define RFA_OFS_FLVL 12'h034
`define RFA_OFS_IST 12'h038
`define RFA_OFS_IMSK 12'h03C
`define RFA_ADDR_W 12
`define RFA_AMP1_HI 7
`define RFA_AMP1_LO 4
`define RFA_AGC_HI 3
`define RFA_AGC_LO 0
`define RFA_TRIM_HI 5
`define RFA_MON_HI 6
`define RFA_MON_LO 4
`define RFA_ROLL_HI 1
`define RFA_ROLL_LO 0
`define RFA_PDN_HI 5
`define RFA_BYP_BIT 1
`define RFA_MUX_GP_BIT 0
`define RFA_MUX_AUX_BIT 1
`define RFA_FOFS_HI 9
`define RFA_RST_8 8'h00
`define RFA_RST_10 10'h000
`define RFA_RST_32 32'h0000_0000
`define RFA_DEC_LEN 64
`define RFA_RF_BITS 6
`define RFA_SAMP_BITS 10
`define RFA_FIFO_DEPTH 12
`define RFA_I2S_HALF 16
`define RFA_IRQ_N 6
`define RFA_IRQ_OVF 4
`define RFA_IRQ_AUX 5
`endif

// ---- core/rfa_pkg.sv ----
// Types shared by the acquisition control.
// Assumes rfa_map.svh in the include path.
`include "rfa_map.svh"
package rfa_pkg;
    typedef struct packed {
        logic [3:0] amp1_gain;
        logic [3:0] agc_gain;
        logic [5:0] offset_trim;
        logic [2:0] eye_monitor_select;
        logic [1:0] noise_rolloff;
        logic [5:0] powerdown;
        logic bypass_from_monitor;
    } rfa_analog_ctrl_s;

    typedef struct packed {
        logic gp_pair_hi;
        logic aux_sel;
    } rfa_mux_s;

    typedef struct packed {
        logic sck;
        logic ws;
        logic sd;
    } rfa_i2s_s;

    typedef enum logic [0:0] {
        RFA_ACC_IDLE,
        RFA_ACC_DONE
    } rfa_acc_e;
endpackage : rfa_pkg

// ---- test/rfa_acq_ctrl_props.sv ----
// Checker for the acquisition control: APB timing, control outputs, interrupt line.
// Assumes it is bound to rfa_acq_ctrl and sees only its ports.
`timescale 1ns/1ns
module rfa_acq_ctrl_props (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Watched ports
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [5:0] i_rf_sample,
    input wire rfa_pkg::rfa_analog_ctrl_s o_analog_ctrl,
    input wire rfa_pkg::rfa_mux_s o_mux,
    input wire logic [5:0] o_rf_data,
    input wire logic [3:0] o_gp_irq,
    input wire logic o_irq
);
    import rfa_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Register write reaches its control field two edges after the access edge
    property p_wr(logic [31:0] a, logic [7:0] f, logic [7:0] m);
        i_psel && i_penable && i_pwrite && !o_pready && i_paddr == a
            |-> ##2 f == ($past(i_pwdata[7:0], 2) & m);
    endproperty
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held longer than one cycle");
    a_ready_wait: assert property ($rose(i_penable) && i_psel |=> o_pready)
        else $error("ready not one cycle after access start");
    a_err_decode: assert property (o_pready |-> o_pslverr == (i_paddr > 32'h3C || i_paddr[1:0] != 2'h0))
        else $error("error response wrong for address");
    a_gain_ctrl: assert property (p_wr(32'h0, {o_analog_ctrl.amp1_gain, o_analog_ctrl.agc_gain}, 8'hFF))
        else $error("gain fields do not follow write");
    a_trim_ctrl: assert property (p_wr(32'h4, {2'h0, o_analog_ctrl.offset_trim}, 8'h3F))
        else $error("offset trim does not follow write");
    a_cfga_ctrl: assert property (p_wr(32'h8, {1'b0, o_analog_ctrl.eye_monitor_select, 2'h0,
        o_analog_ctrl.noise_rolloff}, 8'h73))
        else $error("monitor select or roll-off does not follow write");
    a_pdn_ctrl: assert property (p_wr(32'hC, {2'h0, o_analog_ctrl.powerdown}, 8'h3F))
        else $error("power-down bits do not follow write");
    a_byp_ctrl: assert property (p_wr(32'h10, {6'h0, o_analog_ctrl.bypass_from_monitor, 1'b0}, 8'h02))
        else $error("bypass does not follow write");
    a_mux_ctrl: assert property (p_wr(32'h14, {6'h0, o_mux.aux_sel, o_mux.gp_pair_hi}, 8'h03))
        else $error("mux select does not follow write");
    a_rf_pass: assert property ($past(i_rst_n) |-> o_rf_data == $past(i_rf_sample))
        else $error("RF sample not passed one cycle later");
    a_irq_line: assert property ((|o_gp_irq) |-> ##[0:1] o_irq)
        else $error("interrupt line missing for GP request");
    c_gain_wr: cover property (i_psel && i_penable && i_pwrite && i_paddr == 32'h0);
    c_slverr: cover property (o_pready && o_pslverr);
    c_irq: cover property ($rose(o_irq));
endmodule : rfa_acq_ctrl_props

bind rfa_acq_ctrl rfa_acq_ctrl_props u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rf_sample(i_rf_sample),
    .o_analog_ctrl(o_analog_ctrl), .o_mux(o_mux), .o_rf_data(o_rf_data), .o_gp_irq(o_gp_irq),
    .o_irq(o_irq));

// ---- test/rfa_front_model.sv ----
// Analog front model: RF converter samples and PDM bits of the shared converters.
// Assumes the block's mux outputs choose which sources reach the converters.
`timescale 1ns/1ns
module rfa_front_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Mux from the block
    input wire rfa_pkg::rfa_mux_s i_mux,
    // Converter data
    output logic [5:0] o_rf_sample,
    output logic [1:0] o_gp_pdm,
    output logic [1:0] o_lf_pdm
);
    import rfa_pkg::*;
    logic [1:0] ph_r;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_r <= 2'h0;
            o_rf_sample <= 6'h00;
        end else begin
            ph_r <= ph_r + 2'h1;
            o_rf_sample <= o_rf_sample + 6'h01;
        end
    end
    // Half scale is two cycles high, two low, so the block's glitch filter passes it
    // Inputs a,b give full scale and zero; c half scale, d full scale
    assign o_gp_pdm = i_mux.gp_pair_hi ? {1'b1, ph_r[1]} : 2'b01;
    // Aux left full scale, right zero; diodes alternate when selected
    assign o_lf_pdm = i_mux.aux_sel ? 2'b01 : {ph_r[1], ~ph_r[1]};
endmodule : rfa_front_model

// ---- test/rfa_acq_ctrl_tb.sv ----
// Self-checking bench for the acquisition control with the analog front model.
// Assumes DEC_LEN of 8 and the byte offsets of the register map.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module rfa_acq_ctrl_tb;
    import rfa_pkg::*;
    typedef struct {logic [31:0] a; logic [31:0] d;} rfa_row_s;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [31:0] paddr, pwdata, prdata, rd, lv, sh, wsr;
    logic [5:0] rf_sample, rf_data;
    logic [1:0] gp_pdm, lf_pdm;
    logic [3:0] gp_irq;
    rfa_analog_ctrl_s actl, ex;
    rfa_mux_s mux;
    rfa_i2s_s i2s;
    int checked = 0, mismatches = 0, cycles = 0;
    rfa_row_s rows[6] = '{'{32'h0, 32'hA5}, '{32'h4, 32'h2B}, '{32'h8, 32'h53},
        '{32'hC, 32'h3F}, '{32'h10, 32'h02}, '{32'h14, 32'h03}};

    rfa_acq_ctrl #(.DEC_LEN(8), .FIFO_DEPTH(12)) u_dut (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_rf_sample(rf_sample), .i_gp_pdm(gp_pdm), .i_lf_pdm(lf_pdm), .o_analog_ctrl(actl),
        .o_mux(mux), .o_rf_data(rf_data), .o_i2s(i2s), .o_gp_irq(gp_irq), .o_irq(irq));
    rfa_front_model u_front (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_mux(mux),
        .o_rf_sample(rf_sample), .o_gp_pdm(gp_pdm), .o_lf_pdm(lf_pdm));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task end_of_test;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // One APB transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        `CHK(mux, 2'h0);
        `CHK(actl, 26'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            `CHK(rd, rows[i].d);
            `CHK(er, 1'b0);
        end
        ex = '{4'hA, 4'h5, 6'h2B, 3'h5, 2'h3, 6'h3F, 1'b1};
        `CHK(actl, ex);
        `CHK(mux, 2'h3);
        repeat (200) @(posedge core_clk);
        // One I2S frame: wait for the left half to begin, then take data at each bit clock high
        do @(posedge core_clk); while (i2s.ws !== 1'b1);
        do @(posedge core_clk); while (i2s.ws !== 1'b0);
        for (int i = 0; i < 32; i++) begin
            do @(posedge core_clk); while (i2s.sck !== 1'b1);
            sh = {sh[30:0], i2s.sd};
            wsr = {wsr[30:0], i2s.ws};
        end
        `CHK(sh, 32'hFFC0_0000);
        `CHK(wsr, 32'h0000_FFFF);
        apb(1'b0, 32'h34, 32'h0);
        `CHK(rd, 32'hC);
        apb(1'b0, 32'h38, 32'h0);
        `CHK(rd[4], 1'b1);
        apb(1'b0, 32'h28, 32'h0);
        `CHK(rd, 32'h1FF);
        apb(1'b0, 32'h2C, 32'h0);
        `CHK(rd, 32'h3FF);
        apb(1'b1, 32'h14, 32'h0);
        repeat (24) @(posedge core_clk);
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, 32'h30, 32'h0);
            if (i == 10) lv = rd;
        end
        `CHK(lv, 32'h3FF);
        `CHK(rd, 32'h0);
        apb(1'b0, 32'h34, 32'h0);
        `CHK(rd, 32'h0);
        repeat (40) @(posedge core_clk);
        apb(1'b0, 32'h20, 32'h0);
        `CHK(rd, 32'h3FF);
        apb(1'b0, 32'h24, 32'h0);
        `CHK(rd, 32'h0);
        apb(1'b1, 32'h3C, 32'h1);
        repeat (20) @(posedge core_clk);
        `CHK(irq, 1'b1);
        `CHK(gp_irq, 4'h1);
        apb(1'b1, 32'h3C, 32'h0);
        apb(1'b1, 32'h38, 32'h3F);
        repeat (3) @(posedge core_clk);
        `CHK(irq, 1'b0);
        `CHK(gp_irq, 4'h0);
        apb(1'b1, 32'h0, 32'hA7);
        repeat (2) @(posedge core_clk);
        `CHK(actl.agc_gain, 4'h7);
        `CHK(actl.amp1_gain, 4'hA);
        apb(1'b1, 32'h40, 32'hFF);
        `CHK(er, 1'b1);
        apb(1'b0, 32'h40, 32'h0);
        `CHK(rd, 32'h0);
        apb(1'b0, 32'h2, 32'h0);
        `CHK(er, 1'b1);
        end_of_test();
    end
endmodule : rfa_acq_ctrl_tb
